// ==== sms_consts.vh ====
// Register addresses, control bit positions, reset values and timing counts of the serial unit
`ifndef SMS_CONSTS_VH
`define SMS_CONSTS_VH
`define SMS_ADDR_TX 8'hd4
`define SMS_ADDR_RX 8'hd5
`define SMS_ADDR_CTL 8'hd6
`define SMS_ADDR_IEN 8'hd7
`define SMS_ADDR_DIV 8'hd2
`define SMS_ADDR_STAT 8'hd3
`define SMS_CTL_TE 6
`define SMS_CTL_RE 5
`define SMS_CTL_EN 4
`define SMS_CTL_SSEL 3
`define SMS_CTL_LSB 2
`define SMS_CTL_POL 1
`define SMS_CTL_MASK 8'h7e
`define SMS_CTL_RST 8'h00
`define SMS_IEN_MASK 8'h0f
`define SMS_IEN_RST 8'h00
`define SMS_DIV_RST 8'h04
`define SMS_DIV_MIN 6'h01
`define SMS_ST_TEMPTY 3
`define SMS_ST_OVR 2
`define SMS_ST_TDONE 1
`define SMS_ST_RFULL 0
`define SMS_ST_BUSY 4
`define SMS_ST_TFULL 5
`define SMS_ST_RAVAIL 6
`define SMS_BITS 4'h8
`define SMS_LAST_BIT 3'h7
`define SMS_FIFO_DEPTH 2
`define SMS_ZERO8 8'h00
`endif

// ==== sms_buf2.v ====
// Two-entry byte buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "sms_consts.vh"
module sms_buf2 (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [7:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [7:0] out_data
);
  reg [7:0] mem_q [0:1];
  reg wp_q;
  reg rp_q;
  reg [1:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rp_q];
  always @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
  always @(posedge clk) begin
    if (!rst_n) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // sms_buf2
`default_nettype wire

// ==== sms_spi_master.v ====
// Master-only full-duplex byte serial unit with its register port
// Operation
// - Master only, 8-bit full-duplex bytes
// - Gated clock, one period per bit
// - Change data one edge, sample opposite
// - First bit driven at first clock edge
// - Eight bits out, eight in, exchanged
// - Bit order applies both directions
// - Polarity 0: launch on rising edge
// - Polarity 1: launch on falling edge
// - Sample on edge opposite to launch
// - No collision detect, single master
// - Transmit and receive double buffered
// - Transmit holding register write only
// - Receive holding register read only
// - Full and empty flags, enabled interrupts
// - Reset returns interface to defaults
// - Serial clock derived from system clock
// - Divider resets to divide by four
// - Divisor multiples of four, 4 to 252
// - Select low per byte when enabled
// - Transmitter off holds clock at polarity if enabled
// - Status read clears cause flags
`timescale 1ns/1ps
`default_nettype none
`include "sms_consts.vh"
module sms_spi_master (
  // Clock and reset
  input wire CLK_SYS,
  input wire RST_N,
  // Special-function register port
  input wire [7:0] SFR_ADDR,
  input wire SFR_WR,
  input wire SFR_RD,
  input wire [7:0] SFR_WDATA,
  output reg [7:0] SFR_RDATA,
  output reg SPI_IRQ,
  // Serial lines
  input wire SERIAL_IN_LINE,
  output reg SERIAL_OUT_LINE,
  output reg SERIAL_CLOCK_LINE,
  output reg SLAVE_SELECT_LINE_N
);
  localparam ST_IDLE = 2'h0;
  localparam ST_SEL = 2'h1;
  localparam ST_SHIFT = 2'h2;
  localparam ST_DONE = 2'h3;

  reg [7:0] ctl_q;
  reg [7:0] ien_q;
  reg [7:0] div_q;
  reg [3:0] flag_q;
  reg [1:0] st_q;
  reg [5:0] pre_q;
  reg [1:0] ph_q;
  reg [2:0] bit_q;
  reg [7:0] tsh_q;
  reg [7:0] rsh_q;
  reg [7:0] rx_hold_q;
  reg rx_avail_q;
  reg [2:0] in_sync_q;
  reg in_q;
  reg cap_pend_q;

  wire te = ctl_q[`SMS_CTL_TE];
  wire re = ctl_q[`SMS_CTL_RE];
  wire en = ctl_q[`SMS_CTL_EN];
  wire ssel = ctl_q[`SMS_CTL_SSEL];
  wire lsb = ctl_q[`SMS_CTL_LSB];
  wire pol = ctl_q[`SMS_CTL_POL];

  // Divisor of 4*N: the prescaler gives one tick per quarter serial period
  wire [5:0] div_n = (div_q[7:2] == 6'h00) ? `SMS_DIV_MIN : div_q[7:2];
  wire tick = (pre_q == 6'h00);

  // Transmit buffer: register write fills, the shifter drains
  wire tx_wr = SFR_WR && (SFR_ADDR == `SMS_ADDR_TX);
  wire tb_in_ready;
  wire tb_out_valid;
  wire [7:0] tb_out_data;
  wire tx_take;
  sms_buf2 u_txbuf (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .in_valid(tx_wr),
    .in_ready(tb_in_ready),
    .in_data(SFR_WDATA),
    .out_valid(tb_out_valid),
    .out_ready(tx_take),
    .out_data(tb_out_data)
  );

  // Single master, so a frame starts without any bus arbitration
  wire go = en && te && tb_out_valid;
  assign tx_take = (st_q == ST_IDLE) && go && tick;
  wire rd_stat = SFR_RD && (SFR_ADDR == `SMS_ADDR_STAT);
  wire rd_rx = SFR_RD && (SFR_ADDR == `SMS_ADDR_RX);
  // The last bit is captured in the done state, so the byte completes there
  wire byte_end = (st_q == ST_DONE);
  // Agreeing stages 2 and 3 are taken at once; saves a cycle of pin lag
  wire in_v = (in_sync_q[1] == in_sync_q[2]) ? in_sync_q[2] : in_q;
  wire [7:0] rx_byte = lsb ? {in_v, rsh_q[7:1]} : {rsh_q[6:0], in_v};

  // Receive pin crosses three stages; a change counts once stages 2 and 3 agree
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      in_sync_q <= 3'h0;
      in_q <= 1'b0;
    end else begin
      in_sync_q <= {in_sync_q[1:0], SERIAL_IN_LINE};
      if (in_sync_q[1] == in_sync_q[2]) begin
        in_q <= in_sync_q[2];
      end
    end
  end

  // Register writes
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ctl_q <= `SMS_CTL_RST;
      ien_q <= `SMS_IEN_RST;
      div_q <= `SMS_DIV_RST;
    end else if (SFR_WR) begin
      if (SFR_ADDR == `SMS_ADDR_CTL) begin
        ctl_q <= SFR_WDATA & `SMS_CTL_MASK;
      end
      if (SFR_ADDR == `SMS_ADDR_IEN) begin
        ien_q <= SFR_WDATA & `SMS_IEN_MASK;
      end
      if (SFR_ADDR == `SMS_ADDR_DIV) begin
        div_q <= {SFR_WDATA[7:2], 2'b00};
      end
    end
  end

  // Prescaler: free running while the interface is enabled
  always @(posedge CLK_SYS) begin
    if (!RST_N || !en) begin
      pre_q <= 6'h00;
    end else if (tick) begin
      pre_q <= div_n - 6'h01;
    end else begin
      pre_q <= pre_q - 6'h01;
    end
  end

  // Bit engine; phases 0,1 first half-period, 2,3 second half
  always @(posedge CLK_SYS) begin
    if (!RST_N || !en) begin
      st_q <= ST_IDLE;
      ph_q <= 2'h0;
      bit_q <= 3'h0;
      tsh_q <= `SMS_ZERO8;
      rsh_q <= `SMS_ZERO8;
      cap_pend_q <= 1'b0;
      SERIAL_OUT_LINE <= 1'b0;
      SERIAL_CLOCK_LINE <= 1'b0;
      SLAVE_SELECT_LINE_N <= 1'b1;
    end else begin
      case (st_q)
        ST_IDLE: begin
          SERIAL_CLOCK_LINE <= pol;
          SLAVE_SELECT_LINE_N <= 1'b1;
          if (tx_take) begin
            tsh_q <= tb_out_data;
            st_q <= ST_SEL;
            SLAVE_SELECT_LINE_N <= ~ssel;
          end
        end
        ST_SEL: begin
          // Two quarter periods of select setup before the first clock edge (this state, then phase 0)
          if (tick) begin
            st_q <= ST_SHIFT;
            ph_q <= 2'h0;
            bit_q <= 3'h0;
          end
        end
        ST_SHIFT: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            if (ph_q == 2'h0) begin
              // Leading edge launches the bit, first bit included
              SERIAL_CLOCK_LINE <= ~pol;
              SERIAL_OUT_LINE <= lsb ? tsh_q[0] : tsh_q[7];
              // Previous bit is taken here: the pin path lags up to four cycles,
              // and the slave's new bit cannot reach the stages before this edge
              if (cap_pend_q) begin
                rsh_q <= rx_byte;
                cap_pend_q <= 1'b0;
              end
            end
            if (ph_q == 2'h2) begin
              // Trailing edge; the slave samples our data here
              SERIAL_CLOCK_LINE <= pol;
            end
            if (ph_q == 2'h3) begin
              cap_pend_q <= 1'b1;
              tsh_q <= lsb ? {1'b0, tsh_q[7:1]} : {tsh_q[6:0], 1'b0};
              bit_q <= bit_q + 3'h1;
              if (bit_q == `SMS_LAST_BIT) begin
                st_q <= ST_DONE;
              end
            end
          end
        end
        ST_DONE: begin
          // Release select after the eighth bit; back-to-back bytes resume at the next prescaler tick
          SLAVE_SELECT_LINE_N <= 1'b1;
          SERIAL_CLOCK_LINE <= pol;
          rsh_q <= rx_byte;
          cap_pend_q <= 1'b0;
          st_q <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Receive holding register; an unread byte is overwritten and flagged
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      rx_hold_q <= `SMS_ZERO8;
      rx_avail_q <= 1'b0;
    end else if (byte_end && re) begin
      rx_hold_q <= rx_byte;
      rx_avail_q <= 1'b1;
    end else if (rd_rx) begin
      rx_avail_q <= 1'b0;
    end
  end

  // Cause flags: hardware set wins over read clear
  wire [3:0] set_v;
  assign set_v[`SMS_ST_TEMPTY] = tx_take && tb_in_ready;
  assign set_v[`SMS_ST_OVR] = byte_end && re && rx_avail_q && !rd_rx;
  assign set_v[`SMS_ST_TDONE] = byte_end;
  assign set_v[`SMS_ST_RFULL] = byte_end && re;
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      flag_q <= 4'h0;
      SPI_IRQ <= 1'b0;
    end else begin
      flag_q <= (rd_stat ? 4'h0 : flag_q) | set_v;
      SPI_IRQ <= |(((rd_stat ? 4'h0 : flag_q) | set_v) & ien_q[3:0]);
    end
  end

  // Read data, registered; the transmit register reads as zero
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      SFR_RDATA <= `SMS_ZERO8;
    end else if (SFR_RD) begin
      case (SFR_ADDR)
        `SMS_ADDR_RX: SFR_RDATA <= rx_hold_q;
        `SMS_ADDR_CTL: SFR_RDATA <= ctl_q;
        `SMS_ADDR_IEN: SFR_RDATA <= ien_q;
        `SMS_ADDR_DIV: SFR_RDATA <= div_q;
        `SMS_ADDR_STAT: SFR_RDATA <= {1'b0, rx_avail_q, ~tb_in_ready, st_q != ST_IDLE,
          flag_q};
        default: SFR_RDATA <= `SMS_ZERO8;
      endcase
    end
  end
endmodule // sms_spi_master
`default_nettype wire

// ==== sms_spi_master_assertions.sv ====
// Port-level checker for the serial unit
`timescale 1ns/1ps
`default_nettype none
`include "sms_consts.vh"
module sms_chk (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Register port
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  input wire logic [7:0] SFR_RDATA,
  // Serial lines
  input wire logic SERIAL_OUT_LINE,
  input wire logic SERIAL_CLOCK_LINE,
  input wire logic SLAVE_SELECT_LINE_N
);
  logic [7:0] ctl_q, div_q;
  logic [15:0] run_q;
  logic [3:0] ecnt_q;
  logic last_q;
  wire logic pol = ctl_q[`SMS_CTL_POL];
  wire logic sel = !SLAVE_SELECT_LINE_N;
  wire logic trail = SERIAL_CLOCK_LINE != last_q && SERIAL_CLOCK_LINE == pol;
  wire logic [6:0] half = {(div_q[7:2] == 6'h00) ? 6'h01 : div_q[7:2], 1'b0};
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ctl_q <= `SMS_CTL_RST;
      div_q <= `SMS_DIV_RST;
      last_q <= 1'b0;
      run_q <= 16'h0000;
      ecnt_q <= 4'h0;
    end else begin
      if (SFR_WR && SFR_ADDR == `SMS_ADDR_CTL) ctl_q <= SFR_WDATA;
      if (SFR_WR && SFR_ADDR == `SMS_ADDR_DIV) div_q <= {SFR_WDATA[7:2], 2'b00};
      last_q <= SERIAL_CLOCK_LINE;
      // Idle gaps run the count on past a half period, so it is only judged inside a frame
      run_q <= (SERIAL_CLOCK_LINE != last_q) ? 16'h0001 : run_q + 16'h0001;
      ecnt_q <= sel ? ecnt_q + {3'h0, trail} : 4'h0;
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  park_a: assert property (
    (!ctl_q[`SMS_CTL_TE] && $stable(ctl_q)) [*3] |-> SERIAL_CLOCK_LINE == pol)
    else $error("clock off park level");
  sel_gate_a: assert property ($fell(SLAVE_SELECT_LINE_N) |-> ctl_q[`SMS_CTL_SSEL])
    else $error("select without enable");
  sel_end_a: assert property (
    $rose(SLAVE_SELECT_LINE_N) |-> ecnt_q == 4'h8 && SERIAL_CLOCK_LINE == pol)
    else $error("frame not eight periods");
  half_per_a: assert property (trail && sel |-> run_q == {9'h000, half})
    else $error("bad half period");
  first_edge_a: assert property (
    $fell(SLAVE_SELECT_LINE_N) |-> ##[1:126] SERIAL_CLOCK_LINE != pol)
    else $error("no first clock edge");
  launch_a: assert property (
    $changed(SERIAL_OUT_LINE) && sel |-> $changed(SERIAL_CLOCK_LINE) && SERIAL_CLOCK_LINE != pol)
    else $error("data moved off launch edge");
  tx_rd_a: assert property (SFR_RD && SFR_ADDR == `SMS_ADDR_TX |=> SFR_RDATA == `SMS_ZERO8)
    else $error("transmit holding readable");
  div_rd_a: assert property (SFR_RD && SFR_ADDR == `SMS_ADDR_DIV |=> SFR_RDATA == div_q)
    else $error("divider readback");
  cover property ($rose(SLAVE_SELECT_LINE_N) && ctl_q[`SMS_CTL_LSB]);
  cover property (trail && sel && pol);
  cover property (!ctl_q[`SMS_CTL_TE] && ctl_q[`SMS_CTL_EN] && pol);
endmodule // sms_chk
bind sms_spi_master sms_chk i_sms_chk (.*);
`default_nettype wire

// ==== sms_slave_model.sv ====
// Behavioural serial slave on the far side of the unit
`timescale 1ns/1ps
`default_nettype none
module sms_slave_model (
  // Serial lines
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic mosi,
  output var logic miso,
  // Set-up and data
  input wire logic pol,
  input wire logic lsb,
  input wire logic [7:0] tx,
  output var logic [7:0] rx
);
  int n = 0;
  initial miso = 1'b0;
  always @(sclk) begin
    if (!sel_n && sclk !== pol) begin
      miso <= lsb ? tx[n] : tx[7 - n];
    end else if (!sel_n) begin
      rx[lsb ? n : 7 - n] <= mosi;
      n <= n + 1;
    end
  end
  // A released line must not keep the last bit, or a stale sample passes
  always @(posedge sel_n) begin
    n <= 0;
    miso <= ~miso;
  end
endmodule // sms_slave_model
`default_nettype wire

// ==== tb_sms_spi_master.sv ====
// Bench for the serial unit: registers, all modes, back-to-back, parking
`timescale 1ns/1ps
`default_nettype none
`include "sms_consts.vh"
module tb_sms_spi_master;
  logic CLK_SYS = 1'b0, RST_N = 1'b0, SFR_WR = 1'b0, SFR_RD = 1'b0;
  logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, mode = 8'h00, s_tx = 8'h00;
  logic [7:0] SFR_RDATA, rd_v, s_rx;
  logic SPI_IRQ, SERIAL_IN_LINE, SERIAL_OUT_LINE, SERIAL_CLOCK_LINE, SLAVE_SELECT_LINE_N;
  int err_total = 0, n_compared = 0;
  always #5 CLK_SYS = ~CLK_SYS;
  sms_spi_master i_sms_spi_master (.*);
  sms_slave_model i_sms_slave_model (.sclk(SERIAL_CLOCK_LINE), .sel_n(SLAVE_SELECT_LINE_N),
    .mosi(SERIAL_OUT_LINE), .miso(SERIAL_IN_LINE), .pol(mode[1]), .lsb(mode[2]),
    .tx(s_tx), .rx(s_rx));
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    SFR_ADDR = a;
    SFR_WDATA = d;
    SFR_WR = 1'b1;
    tick(1);
    SFR_WR = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    SFR_ADDR = a;
    SFR_RD = 1'b1;
    tick(1);
    SFR_RD = 1'b0;
    tick(1);
    rd_v = SFR_RDATA;
  endtask
  task automatic chk(input logic [7:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic t_reset;
    rd(`SMS_ADDR_DIV);
    chk(rd_v, `SMS_DIV_RST);
    rd(`SMS_ADDR_TX);
    chk(rd_v, `SMS_ZERO8);
    chk({5'h00, SPI_IRQ, SERIAL_CLOCK_LINE, SLAVE_SELECT_LINE_N}, 8'h01);
  endtask
  // Control goes first so the clock has settled at its new park level
  task automatic t_xfer(input logic [7:0] m, dv, mb, sb);
    int k;
    mode = m;
    s_tx = sb;
    wr(`SMS_ADDR_CTL, m);
    wr(`SMS_ADDR_DIV, dv);
    wr(`SMS_ADDR_TX, mb);
    while (SERIAL_CLOCK_LINE === m[1]) tick(1);
    k = 0;
    while (SERIAL_CLOCK_LINE !== m[1] && k < 300) begin
      tick(1);
      k++;
    end
    chk(8'(k), {1'b0, (dv[7:2] == 6'h00) ? 6'h01 : dv[7:2], 1'b0});
    rd_v = 8'h00;
    for (k = 0; k < 300 && rd_v[`SMS_ST_TDONE] !== 1'b1; k++) rd(`SMS_ADDR_STAT);
    rd(`SMS_ADDR_STAT);
    chk(rd_v & 8'h02, 8'h00);
    rd(`SMS_ADDR_RX);
    chk(rd_v, sb);
    chk(s_rx, mb);
  endtask
  task automatic t_b2b;
    s_tx = 8'hc3;
    wr(`SMS_ADDR_IEN, 8'h02);
    wr(`SMS_ADDR_TX, 8'h81);
    wr(`SMS_ADDR_TX, 8'h42);
    @(posedge SLAVE_SELECT_LINE_N);
    chk(s_rx, 8'h81);
    s_tx = 8'h3c;
    #1;
    chk({7'h00, SPI_IRQ}, 8'h01);
    rd(`SMS_ADDR_RX);
    chk(rd_v, 8'hc3);
    @(posedge SLAVE_SELECT_LINE_N);
    #1;
    chk(s_rx, 8'h42);
    rd(`SMS_ADDR_RX);
    chk(rd_v, 8'h3c);
  endtask
  task automatic t_park;
    mode = 8'h1a;
    wr(`SMS_ADDR_CTL, 8'h1a);
    wr(`SMS_ADDR_TX, 8'h55);
    tick(40);
    chk({6'h00, SERIAL_CLOCK_LINE, SLAVE_SELECT_LINE_N}, 8'h03);
    rd(`SMS_ADDR_STAT);
    chk({7'h00, SPI_IRQ}, 8'h00);
  endtask
  initial begin
    tick(3);
    RST_N = 1'b1;
    t_reset;
    t_xfer(8'h78, 8'h04, 8'ha5, 8'h1e);
    t_xfer(8'h7a, 8'h00, 8'h3c, 8'hd2);
    t_xfer(8'h7c, 8'h08, 8'h81, 8'h6b);
    t_xfer(8'h7e, 8'h0b, 8'hc4, 8'h59);
    t_b2b;
    t_park;
    close_out;
  end
  // Whole run needs well under a thousand cycles; this allows twenty thousand
  initial begin
    #200000;
    err_total++;
    close_out;
  end
endmodule // tb_sms_spi_master
`default_nettype wire
